// ### core/adc_frontend_config.v
// configuration logic for primary and auxiliary sigma-delta front ends
// assumes clk is the converter clock; sinc3 samples arrive on the same clock
`include "adc_frontend_consts.vh"
module adc_frontend_config (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  input  wire [23:0] sinc_data,
  input  wire        sinc_valid,
  output reg  [23:0] result_data,
  output reg         result_valid,
  output reg  [1:0]  primary_ref_select,
  output reg  [2:0]  aux_ref_select,
  output reg         primary_high_ref_flag,
  output reg         aux_high_ref_flag,
  output reg  [1:0]  primary_diag_current_sel,
  output reg  [1:0]  aux_diag_current_sel,
  output reg  [6:0]  decimation_word,
  output reg         chop_enable,
  output reg         chop_swap,
  output reg  [3:0]  primary_gain_sel,
  output reg         primary_gain_enable,
  output reg  [3:0]  excitation_level,
  output reg         excitation0_on,
  output reg         excitation1_on,
  output reg         excitation0_route,
  output reg         excitation1_route,
  output reg  [1:0]  converter_mode,
  output reg         low_power,
  output reg         int_ref_power_save,
  output reg         slow_clock
);
  reg  [15:0] pctl_reg;
  reg  [15:0] actl_reg;
  reg  [15:0] filt_reg;
  reg  [15:0] exc_reg;
  reg  [7:0]  mode_reg;
  reg  [23:0] prev_reg;
  reg         have_prev_reg;
  reg  [15:0] rd_next;
  reg  [6:0]  decim_next;
  reg  [1:0]  mode_next;
  reg  [3:0]  gain_next;
  reg  [3:0]  level_next;
  reg  [1:0]  pref_next;
  reg  [2:0]  aref_next;
  wire [24:0] avg_sum;
  wire        ext_in_use;
  wire        primary_ext;
  wire        aux_ext;
  wire [1:0]  src_on;
  wire [1:0]  src_route;
  genvar      s;

  // clamp illegal writes so no field but the primary diag select runs outside the legal range;
  // clamping rather than ignoring keeps a stray write from leaving old state
  always @* begin
    decim_next = wdata[6:0];                                   // [R8]
    if (wdata[6:0] < `DECIM_MIN) begin
      decim_next = `DECIM_MIN;                                 // [R9]
    end
    mode_next = wdata[`M_MODE_LSB+1:`M_MODE_LSB];
    if (mode_next == 2'h3) begin
      mode_next = `MODE_NORMAL;                                // [R15]
    end
    gain_next = wdata[`P_GAIN_LSB+3:`P_GAIN_LSB];
    if (gain_next > `GAIN_MAX) begin
      gain_next = `GAIN_MAX;                                   // [R11]
    end
    level_next = wdata[`X_LEVEL_LSB+3:`X_LEVEL_LSB];
    if (level_next > `LEVEL_MAX) begin
      level_next = `LEVEL_MAX;                                 // [R12]
    end
    pref_next = wdata[`P_REF_LSB+1:`P_REF_LSB];
    if (pref_next == 2'h3) begin
      pref_next = `REF_INTERNAL;                               // [R2]
    end
    aref_next = wdata[`A_REF_LSB+2:`A_REF_LSB];
    if (aref_next > {1'b0, `REF_SECOND_PAIR}) begin
      aref_next = {1'b0, `REF_INTERNAL};                       // [R2]
    end
  end

  // primary control: gain, reference, diagnostic currents, high-ref flag
  always @(posedge clk) begin
    if (!reset_n) begin
      pctl_reg <= `PRIMARY_CTRL_RESET;                         // [R1]
    end else if (wr && addr == `ADDR_PRIMARY_CTRL) begin
      pctl_reg <= {7'h00, wdata[`P_HIGH_REF_BIT], wdata[`P_DIAG_LSB+1:`P_DIAG_LSB],
                   pref_next, gain_next};                      // [R3]
    end
  end

  // auxiliary control: reference, diagnostic currents, high-ref flag
  always @(posedge clk) begin
    if (!reset_n) begin
      actl_reg <= `AUX_CTRL_RESET;                             // [R1]
    end else if (wr && addr == `ADDR_AUX_CTRL) begin
      actl_reg <= {10'h000, wdata[`A_HIGH_REF_BIT], wdata[`A_DIAG_LSB+1:`A_DIAG_LSB],
                   aref_next};                                 // [R3]
    end
  end

  // filter: decimation word and chop enable
  always @(posedge clk) begin
    if (!reset_n) begin
      filt_reg <= `FILTER_RESET;
    end else if (wr && addr == `ADDR_FILTER) begin
      filt_reg <= {8'h00, wdata[`F_CHOP_BIT], decim_next};     // [R8]
    end
  end

  // excitation: shared level, per-source route and enable
  always @(posedge clk) begin
    if (!reset_n) begin
      exc_reg <= `EXCITATION_RESET;
    end else if (wr && addr == `ADDR_EXCITATION) begin
      exc_reg <= {8'h00, wdata[7:4], level_next};              // [R12]
    end
  end

  // mode: low bits read back as zero
  always @(posedge clk) begin
    if (!reset_n) begin
      mode_reg <= `MODE_RESET;                                 // [R15]
    end else if (wr && addr == `ADDR_MODE) begin
      mode_reg <= {wdata[7:5], mode_next, 3'h0};               // [R15]
    end
  end

  // one enable bit and one route bit per excitation source
  generate
    for (s = 0; s < 2; s = s + 1) begin : exc_src
      assign src_on[s]    = exc_reg[`X_EN0_BIT + s];           // [R13]
      assign src_route[s] = exc_reg[`X_ROUTE0_BIT + s];        // [R14]
    end
  endgenerate

  // primary reference outputs
  always @(posedge clk) begin
    if (!reset_n) begin
      primary_ref_select       <= 2'h0;
      primary_high_ref_flag    <= 1'b0;
    end else begin
      primary_ref_select       <= pctl_reg[`P_REF_LSB+1:`P_REF_LSB];       // [R3]
      primary_high_ref_flag    <= pctl_reg[`P_HIGH_REF_BIT];               // [R4]
    end
  end

  // auxiliary reference outputs
  always @(posedge clk) begin
    if (!reset_n) begin
      aux_ref_select           <= 3'h0;
      aux_high_ref_flag        <= 1'b0;
    end else begin
      aux_ref_select           <= actl_reg[`A_REF_LSB+2:`A_REF_LSB];       // [R3]
      aux_high_ref_flag        <= actl_reg[`A_HIGH_REF_BIT];               // [R5]
    end
  end

  // diagnostic current selects
  always @(posedge clk) begin
    if (!reset_n) begin
      primary_diag_current_sel <= 2'h0;
      aux_diag_current_sel     <= 2'h0;
    end else begin
      // value 2 is undefined for the primary pair; it is passed on unchanged
      primary_diag_current_sel <= pctl_reg[`P_DIAG_LSB+1:`P_DIAG_LSB];     // [R6]
      aux_diag_current_sel     <= actl_reg[`A_DIAG_LSB+1:`A_DIAG_LSB];     // [R7]
    end
  end

  // filter outputs
  always @(posedge clk) begin
    if (!reset_n) begin
      decimation_word          <= `DECIM_MIN;
      chop_enable              <= 1'b0;
    end else begin
      decimation_word          <= filt_reg[6:0];                           // [R8]
      chop_enable              <= filt_reg[`F_CHOP_BIT];                   // [R10]
    end
  end

  // gain amplifier outputs
  always @(posedge clk) begin
    if (!reset_n) begin
      primary_gain_sel         <= 4'h0;
      primary_gain_enable      <= 1'b1;
    end else begin
      primary_gain_sel         <= pctl_reg[`P_GAIN_LSB+3:`P_GAIN_LSB];     // [R11]
      primary_gain_enable      <= (mode_reg[4:3] != `MODE_LOW_POWER_PLUS); // [R16]
    end
  end

  // excitation outputs; both routes may name one pin, doubling its current
  always @(posedge clk) begin
    if (!reset_n) begin
      excitation_level         <= 4'h0;
      excitation0_on           <= 1'b0;
      excitation1_on           <= 1'b0;
      excitation0_route        <= 1'b0;
      excitation1_route        <= 1'b0;
    end else begin
      excitation_level         <= exc_reg[`X_LEVEL_LSB+3:`X_LEVEL_LSB];    // [R12]
      excitation0_on           <= src_on[0];                               // [R13]
      excitation1_on           <= src_on[1];                               // [R13]
      excitation0_route        <= src_route[0];                            // [R14]
      excitation1_route        <= src_route[1];                            // [R14]
    end
  end

  // operating mode outputs
  always @(posedge clk) begin
    if (!reset_n) begin
      converter_mode           <= `MODE_NORMAL;
      low_power                <= 1'b0;
    end else begin
      converter_mode           <= mode_reg[`M_MODE_LSB+1:`M_MODE_LSB];     // [R15]
      // rate ceiling in low power is left to software; no rate is enforced here
      low_power                <= (mode_reg[4:3] != `MODE_NORMAL);         // [R16][R17]
    end
  end

  // power saving outputs
  always @(posedge clk) begin
    if (!reset_n) begin
      int_ref_power_save       <= 1'b0;
      slow_clock               <= 1'b0;
    end else begin
      // power saving is meaningless while an external reference is in use
      int_ref_power_save       <= !mode_reg[`M_REF_ON_BIT] && !ext_in_use; // [R18]
      slow_clock               <= !mode_reg[`M_FAST_CLK_BIT];              // [R19]
    end
  end

  assign primary_ext = (pctl_reg[`P_REF_LSB+1:`P_REF_LSB] != `REF_INTERNAL);
  assign aux_ext     = (actl_reg[`A_REF_LSB+2:`A_REF_LSB] != {1'b0, `REF_INTERNAL});
  assign ext_in_use  = primary_ext || aux_ext;

  // chop stage: polarity toggles per filter output, result is running pair mean
  // a pair mean keeps the offset cancel exact; longer averaging needs a wider sum
  assign avg_sum = {sinc_data[23], sinc_data} + {prev_reg[23], prev_reg};

  // input polarity, flipped on every filter output while chopping
  always @(posedge clk) begin
    if (!reset_n) begin
      chop_swap <= 1'b0;
    end else if (!filt_reg[`F_CHOP_BIT]) begin
      chop_swap <= 1'b0;
    end else if (sinc_valid) begin
      chop_swap <= ~chop_swap;                                 // [R10]
    end
  end

  // previous output; forgotten with chop off so a stale half never pairs
  always @(posedge clk) begin
    if (!reset_n) begin
      prev_reg      <= 24'h000000;
      have_prev_reg <= 1'b0;
    end else if (!filt_reg[`F_CHOP_BIT]) begin
      have_prev_reg <= 1'b0;
    end else if (sinc_valid) begin
      prev_reg      <= sinc_data;
      have_prev_reg <= 1'b1;
    end
  end

  // data register value and its one-cycle strobe
  always @(posedge clk) begin
    if (!reset_n) begin
      result_data  <= 24'h000000;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (sinc_valid && !filt_reg[`F_CHOP_BIT]) begin
        result_data  <= sinc_data;
        result_valid <= 1'b1;
      end
      if (sinc_valid && filt_reg[`F_CHOP_BIT] && have_prev_reg) begin
        result_data  <= avg_sum[24:`CHOP_AVG_SHIFT];           // [R10]
        result_valid <= 1'b1;
      end
    end
  end

  // read mux; status shows live chop and power state for polling
  always @* begin
    case (addr)
      `ADDR_PRIMARY_CTRL: rd_next = pctl_reg;
      `ADDR_AUX_CTRL:     rd_next = actl_reg;
      `ADDR_FILTER:       rd_next = filt_reg;
      `ADDR_EXCITATION:   rd_next = exc_reg;
      `ADDR_MODE:         rd_next = {8'h00, mode_reg};
      `ADDR_STATUS:       rd_next = {12'h000, have_prev_reg, chop_swap, low_power,
                                     int_ref_power_save};
      default:            rd_next = 16'h0000;
    endcase
  end

  // read data stands only in the cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      rdata <= rd_next;
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule

// ### core/adc_frontend_consts.vh
// register offsets, field positions and reset values for adc_frontend_config
// assumes a word-indexed plain register port with 4-bit address
// Operation
// R1 - after reset both converters use the on-chip reference
// R2 - reference choices: internal, external pair, or second pair on input pins
// R3 - primary reference from 2-bit field, auxiliary from 3-bit field
// R4 - software sets primary high-ref flag for external reference above 1.35 V
// R5 - software sets auxiliary high-ref flag for external reference above 1.35 V
// R6 - primary diag field: 0 off, 1 first input, 3 both inputs
// R7 - auxiliary diag field enables test currents on selected aux inputs
// R8 - sinc3 decimation factor is filter register bits 6 to 0
// R9 - without chop decimation word stays between 3 and 127
// R10 - chop swaps input polarity and averages outputs before data register
// R11 - primary gain: ten settings 1 to 512 from a 4-bit field
// R12 - each excitation source level set by 4-bit field in 200 uA steps
// R13 - excitation source 0 on only with bit 6, source 1 with bit 7
// R14 - route bits can steer both sources to one pin
// R15 - mode register bits 4 to 3 select normal, low-power, low-power-plus
// R16 - low-power-plus equals low-power with primary gain amplifier off
// R17 - low-power output rate at most 2 kHz; software programs filter
// R18 - clearing mode bit 5 puts internal reference in power saving; here only while neither converter selects an external reference
// R19 - clearing mode bit 7 lowers converter clock frequency
`ifndef ADC_FRONTEND_CONSTS_VH
`define ADC_FRONTEND_CONSTS_VH
`define ADDR_PRIMARY_CTRL   4'h0
`define ADDR_AUX_CTRL       4'h1
`define ADDR_FILTER         4'h2
`define ADDR_EXCITATION     4'h3
`define ADDR_MODE           4'h4
`define ADDR_STATUS         4'h5
`define PRIMARY_CTRL_RESET  16'h0000
`define AUX_CTRL_RESET      16'h0000
`define FILTER_RESET        16'h0003
`define EXCITATION_RESET    16'h0000
`define MODE_RESET          8'ha0
// primary control fields
`define P_GAIN_LSB          0
`define P_REF_LSB           4
`define P_DIAG_LSB          6
`define P_HIGH_REF_BIT      8
// aux control fields
`define A_REF_LSB           0
`define A_DIAG_LSB          3
`define A_HIGH_REF_BIT      5
// filter fields
`define F_CHOP_BIT          7
// excitation fields
`define X_LEVEL_LSB         0
`define X_ROUTE0_BIT        4
`define X_ROUTE1_BIT        5
`define X_EN0_BIT           6
`define X_EN1_BIT           7
// mode fields
`define M_MODE_LSB          3
`define M_REF_ON_BIT        5
`define M_FAST_CLK_BIT      7
`define MODE_NORMAL         2'h0
`define MODE_LOW_POWER      2'h1
`define MODE_LOW_POWER_PLUS 2'h2
`define REF_INTERNAL        2'h0
`define REF_EXT_PAIR        2'h1
`define REF_SECOND_PAIR     2'h2
`define DECIM_MIN           7'h03
`define GAIN_MAX            4'h9
`define LEVEL_MAX           4'h4
`define CHOP_AVG_SHIFT      1
`endif

// ### verif/adc_frontend_config_asserts.sv
// assertions on the configuration outputs of adc_frontend_config
// assumes reset_n is synchronous, active low, on clk
`include "adc_frontend_consts.vh"
module adc_frontend_config_asserts (
  input logic        clk,
  input logic        reset_n,
  input logic [3:0]  addr,
  input logic [15:0] wdata,
  input logic        wr,
  input logic [23:0] sinc_data,
  input logic        sinc_valid,
  input logic [23:0] result_data,
  input logic        result_valid,
  input logic [1:0]  primary_ref_select,
  input logic [2:0]  aux_ref_select,
  input logic [6:0]  decimation_word,
  input logic        chop_enable,
  input logic [3:0]  primary_gain_sel,
  input logic        primary_gain_enable,
  input logic [3:0]  excitation_level,
  input logic [1:0]  converter_mode,
  input logic        int_ref_power_save
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  reset_vals_a: assert property ($past(!reset_n) |-> decimation_word == 7'h03 &&
    primary_ref_select == 2'h0 && aux_ref_select == 3'h0 && primary_gain_enable)
    else $error("outputs not at reset values after reset");
  decim_write_a: assert property (wr && addr == `ADDR_FILTER && wdata[6:0] >= 7'h03 |->
    ##2 decimation_word == $past(wdata[6:0], 2)) else $error("decimation word not taken");
  decim_range_a: assert property (decimation_word >= 7'h03)
    else $error("decimation word below three");
  gain_range_a: assert property (primary_gain_sel <= 4'h9)
    else $error("gain code beyond ten settings");
  level_range_a: assert property (excitation_level <= 4'h4)
    else $error("excitation level above top step");
  plus_gain_a: assert property (primary_gain_enable == (converter_mode != 2'h2))
    else $error("gain amplifier enable disagrees with mode");
  chop_off_a: assert property (sinc_valid && !chop_enable |=>
    result_valid && result_data == $past(sinc_data)) else $error("unchopped sample not passed");
  ref_save_a: assert property (int_ref_power_save |->
    primary_ref_select == 2'h0 && aux_ref_select == 3'h0) else $error("save with external ref");
endmodule

bind adc_frontend_config adc_frontend_config_asserts chk (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .sinc_data(sinc_data),
  .sinc_valid(sinc_valid), .result_data(result_data), .result_valid(result_valid),
  .primary_ref_select(primary_ref_select), .aux_ref_select(aux_ref_select),
  .decimation_word(decimation_word), .chop_enable(chop_enable),
  .primary_gain_sel(primary_gain_sel), .primary_gain_enable(primary_gain_enable),
  .excitation_level(excitation_level), .converter_mode(converter_mode),
  .int_ref_power_save(int_ref_power_save));

// ### verif/sinc_source.sv
// behavioural sinc3 output source feeding the converter data path
// assumes samples are launched just after a rising clk edge
module sinc_source (
  output logic [23:0] sinc_data,
  output logic        sinc_valid,
  input  logic        clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sinc_data = 24'h000000;
    sinc_valid = 1'b0;
  end
  // released data shows the inverse so a stale value never passes for a sample
  task automatic send(input logic [23:0] v);
    @(posedge clk);
    sinc_data <= v;
    sinc_valid <= 1'b1;
    @(posedge clk);
    sinc_valid <= 1'b0;
    sinc_data <= ~v;
  endtask
endmodule

// ### verif/testbench.sv
// self-checking bench for adc_frontend_config: register rows, then awkward cases
// assumes sinc_source and the checker bind are compiled first
`include "adc_frontend_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  wire  [15:0] rdata;
  wire  [23:0] sinc_data, result_data;
  wire         sinc_valid, result_valid, primary_high_ref_flag, aux_high_ref_flag;
  wire         chop_enable, chop_swap, primary_gain_enable, excitation0_on, excitation1_on;
  wire         excitation0_route, excitation1_route, low_power, int_ref_power_save, slow_clock;
  wire  [1:0]  primary_ref_select, primary_diag_current_sel, aux_diag_current_sel;
  wire  [1:0]  converter_mode;
  wire  [2:0]  aux_ref_select;
  wire  [6:0]  decimation_word;
  wire  [3:0]  primary_gain_sel, excitation_level;
  int          miscompares = 0;
  int          samples_checked = 0;
  logic [3:0]  a;
  logic [15:0] d, eo, er;
  // addr, write data, decoded outputs, read back; high-ref flags only with second pair
  logic [51:0] rows [9] = '{{4'h0, 16'h01e5, 16'h01e5, 16'h01e5},
    {4'h0, 16'h007f, 16'h0049, 16'h0049}, {4'h1, 16'h002a, 16'h002a, 16'h002a},
    {4'h2, 16'h0001, 16'h0003, 16'h0003}, {4'h2, 16'h007f, 16'h007f, 16'h007f},
    {4'h3, 16'h00d4, 16'h00d4, 16'h00d4}, {4'h3, 16'h003f, 16'h0034, 16'h0034},
    {4'h4, 16'h00a8, 16'h0005, 16'h00a8}, {4'h4, 16'h0010, 16'h000a, 16'h0010}};
  adc_frontend_config dut (.*);
  sinc_source src (.clk(clk), .sinc_data(sinc_data), .sinc_valid(sinc_valid));
  always #25 clk = ~clk;
  function automatic logic [15:0] obs(input logic [3:0] k);
    case (k)
      4'h0: obs = {7'h00, primary_high_ref_flag, primary_diag_current_sel, primary_ref_select,
                   primary_gain_sel};
      4'h1: obs = {10'h000, aux_high_ref_flag, aux_diag_current_sel, aux_ref_select};
      4'h2: obs = {8'h00, chop_enable, decimation_word};
      4'h3: obs = {8'h00, excitation1_on, excitation0_on, excitation1_route, excitation0_route,
                   excitation_level};
      default: obs = {12'h000, slow_clock, primary_gain_enable, converter_mode};
    endcase
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] k, input logic [15:0] v);
    @(posedge clk);
    addr <= k;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] k, input logic [15:0] v);
    @(posedge clk);
    addr <= k;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, v});
  endtask
  // decoded outputs trail the register by one more edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic summarize;
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 chk(obs(4'h0), 16'h0000);
    chk(obs(4'h1), 16'h0000);
    chk(obs(4'h2), 16'h0003);
    chk(obs(4'h4), 16'h0004);
    rd_chk(4'h4, 16'h00a0);
    foreach (rows[i]) begin
      {a, d, eo, er} = rows[i];
      wr_reg(a, d);
      settle;
      chk(obs(a), eo);
      rd_chk(a, er);
    end
    wr_reg(4'h1, 16'h0000);
    settle;
    chk(int_ref_power_save, 1'b1);
    wr_reg(4'h0, 16'h0010);
    settle;
    chk(int_ref_power_save, 1'b0);
    wr_reg(4'h6, 16'hffff);
    rd_chk(4'h6, 16'h0000);
    wr_reg(4'h5, 16'hffff);
    rd_chk(4'h5, 16'h0002);
    wr_reg(4'h2, 16'h0010);
    settle;
    src.send(24'h000100);
    #1 chk(result_valid, 1'b1);
    chk(result_data, 24'h000100);
    wr_reg(4'h2, 16'h0083);
    settle;
    src.send(24'hfffff0);
    #1 chk({result_valid, chop_swap}, 2'b01);
    src.send(24'h000030);
    #1 chk({result_valid, chop_swap}, 2'b10);
    chk(result_data, 24'h000010);
    summarize;
  end
  initial begin
    #100000;
    miscompares++;
    summarize;
  end
endmodule
